// ### lanrx_receive_unit.sv
// Receive unit: stores link frames into shared descriptor memory, AHB-Lite register slave.
// Assumes frame bytes come from a link receiver on ref_clk and memory answers each request with one mem_ack pulse.
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module lanrx_receive_unit #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output lanrx_pkg::lanrx_mem_t mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire lanrx_pkg::lanrx_link_t rx,
  output logic rnr_irq,
  output logic fr_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  lanrx_pkg::lanrx_ru_t ru_r, ru_nxt;
  lanrx_pkg::lanrx_sq_t sq_r, sq_nxt, end_target;
  logic [15:0] fd_r, fd_nxt, link_r, bd_r, bd_next_r, prev_bd_r, word_r, new_area_r;
  logic [13:0] size_r, cnt_r, prev_size_r;
  logic [23:0] baddr_r, word_addr_r, base_r;
  logic [3:0] hdr_cnt_r;
  logic fd_el_r, fd_s_r, bd_el_r, prev_valid_r, out_r, end_r, nospace_r, ovr_r, in_buf_r;
  logic crc_r, aln_r, short_r, noeof_r;
  logic pend_start_r, pend_susp_r, in_frame_r, storing_r;
  logic cfg_keep_r, cfg_aib_r, wr_pend_r;
  logic [7:0] wr_addr_r;
  logic rnr_nxt, fr_nxt, take_start, take_susp;
  logic [CNT_W-1:0] crc_cnt_r, aln_cnt_r, ovr_cnt_r, rsc_cnt_r;
  logic m_acc, m_we;
  logic [23:0] m_addr;
  logic [15:0] m_wd;

  function automatic logic [23:0] daddr(input logic [23:0] base, input logic [15:0] off);
    daddr = base + {8'h00, off};
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire ahb_go = hsel && hready && htrans[1];
  wire cmd_wr = wr_pend_r && (wr_addr_r == lanrx_pkg::REG_CMD);
  wire [2:0] cmd_code = cmd_wr ? hwdata[2:0] : lanrx_pkg::CMD_NOP;
  wire [15:0] cmd_area = hwdata[lanrx_pkg::CMD_AREA_LSB +: 16];
  wire acked = mem.req && mem_ack;
  wire quiet = !in_frame_r && (sq_r == lanrx_pkg::SQ_OFF || sq_r == lanrx_pkg::SQ_ARMED);
  wire start_ok = rx.valid && !in_frame_r && ru_r == lanrx_pkg::RU_READY && sq_r == lanrx_pkg::SQ_ARMED
    && !pend_start_r && !pend_susp_r && cmd_code == lanrx_pkg::CMD_NOP;
  wire storing_now = storing_r || start_ok;
  wire byte_ok = rx.valid && storing_now && sq_r == lanrx_pkg::SQ_ARMED && !end_r;
  wire hdr_phase = !cfg_aib_r && (hdr_cnt_r < lanrx_pkg::HDR_LEN);
  wire byte_pos = hdr_phase ? hdr_cnt_r[0] : cnt_r[0];
  wire byte_drop = !hdr_phase && out_r;
  wire wr_byte = byte_ok && !byte_drop && (byte_pos || rx.last);
  wire ovr_now = rx.valid && storing_r && sq_r != lanrx_pkg::SQ_ARMED;
  wire end_evt = rx.valid && rx.last;
  wire err_any = crc_r || aln_r || short_r || noeof_r || nospace_r || ovr_r;
  wire kept = !err_any || cfg_keep_r;
  wire used_buf = (cnt_r != 14'h0000) || prev_valid_r;
  wire [15:0] close_bd = (cnt_r != 14'h0000) ? bd_r : prev_bd_r;
  wire [13:0] close_cnt = (cnt_r != 14'h0000) ? cnt_r : prev_size_r;
  wire [15:0] next_free = out_r ? lanrx_pkg::NO_BD
    : ((cnt_r != 14'h0000) ? (bd_el_r ? lanrx_pkg::NO_BD : bd_next_r) : bd_r);
  wire [15:0] fd_status = (16'h0001 << lanrx_pkg::ST_C) | ({15'h0000, !err_any} << lanrx_pkg::ST_OK)
    | ({15'h0000, crc_r} << lanrx_pkg::ST_CRC) | ({15'h0000, aln_r} << lanrx_pkg::ST_ALN)
    | ({15'h0000, nospace_r} << lanrx_pkg::ST_NOSP) | ({15'h0000, ovr_r} << lanrx_pkg::ST_OVR)
    | ({15'h0000, short_r} << lanrx_pkg::ST_SHORT) | ({15'h0000, noeof_r} << lanrx_pkg::ST_NOEOF);
  wire [31:0] stat_word = {26'h0000000, pend_susp_r, pend_start_r, in_frame_r, sq_r != lanrx_pkg::SQ_OFF, 2'(ru_r)};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == lanrx_pkg::REG_CFG) ? {30'h00000000, cfg_aib_r, cfg_keep_r} :
    (ra == lanrx_pkg::REG_BASE) ? {8'h00, base_r} :
    (ra == lanrx_pkg::REG_STAT) ? stat_word :
    (ra == lanrx_pkg::REG_CRC) ? 32'(crc_cnt_r) :
    (ra == lanrx_pkg::REG_ALN) ? 32'(aln_cnt_r) :
    (ra == lanrx_pkg::REG_OVR) ? 32'(ovr_cnt_r) :
    (ra == lanrx_pkg::REG_RSC) ? 32'(rsc_cnt_r) : 32'h00000000;

  always_comb
  begin
    if (used_buf)
      end_target = lanrx_pkg::SQ_BD_CLOSE;
    else if (!kept)
      end_target = lanrx_pkg::SQ_DISCARD;
    else
      end_target = fd_el_r ? lanrx_pkg::SQ_FD_DONE : lanrx_pkg::SQ_NEXT_BDP;
  end

  // ----------------------------------------
  // Sequencer and unit state
  // ----------------------------------------
  always_comb
  begin
    sq_nxt = sq_r;
    ru_nxt = ru_r;
    fd_nxt = fd_r;
    rnr_nxt = 1'b0;
    fr_nxt = 1'b0;
    take_start = 1'b0;
    take_susp = 1'b0;
    unique case (sq_r)
      lanrx_pkg::SQ_OFF:
        sq_nxt = sq_r;
      lanrx_pkg::SQ_FD_CMD:
        if (acked) sq_nxt = lanrx_pkg::SQ_FD_LINK;
      lanrx_pkg::SQ_FD_LINK:
        if (acked) sq_nxt = lanrx_pkg::SQ_FD_BDP;
      lanrx_pkg::SQ_FD_BDP:
        if (acked && mem_rdata == lanrx_pkg::NO_BD)
        begin
          sq_nxt = lanrx_pkg::SQ_OFF;
          ru_nxt = lanrx_pkg::RU_NORES;
          rnr_nxt = 1'b1;
        end
        else if (acked)
          sq_nxt = lanrx_pkg::SQ_FD_BUSY;
      lanrx_pkg::SQ_FD_BUSY:
        if (acked) sq_nxt = lanrx_pkg::SQ_BD_SIZE;
      lanrx_pkg::SQ_BD_SIZE:
        if (acked) sq_nxt = lanrx_pkg::SQ_BD_ALO;
      lanrx_pkg::SQ_BD_ALO:
        if (acked) sq_nxt = lanrx_pkg::SQ_BD_AHI;
      lanrx_pkg::SQ_BD_AHI:
        if (acked) sq_nxt = lanrx_pkg::SQ_BD_NEXT;
      lanrx_pkg::SQ_BD_NEXT:
        if (acked) sq_nxt = lanrx_pkg::SQ_ARMED;
      lanrx_pkg::SQ_ARMED:
        if (end_r)
          sq_nxt = end_target;
        else if (wr_byte)
          sq_nxt = lanrx_pkg::SQ_WORD;
      lanrx_pkg::SQ_WORD:
        if (acked && end_r)
          sq_nxt = end_target;
        else if (acked && in_buf_r && cnt_r == size_r)
          sq_nxt = lanrx_pkg::SQ_BD_CLOSE;
        else if (acked)
          sq_nxt = lanrx_pkg::SQ_ARMED;
      lanrx_pkg::SQ_BD_CLOSE:
        if (acked && end_r)
          sq_nxt = !kept ? lanrx_pkg::SQ_DISCARD : (fd_el_r ? lanrx_pkg::SQ_FD_DONE : lanrx_pkg::SQ_NEXT_BDP);
        else if (acked)
          sq_nxt = bd_el_r ? lanrx_pkg::SQ_ARMED : lanrx_pkg::SQ_BD_SIZE;
      lanrx_pkg::SQ_NEXT_BDP:
        if (acked) sq_nxt = lanrx_pkg::SQ_FD_DONE;
      lanrx_pkg::SQ_FD_DONE:
        if (acked)
        begin
          fr_nxt = 1'b1;
          fd_nxt = link_r;
          sq_nxt = lanrx_pkg::SQ_OFF;
          rnr_nxt = 1'b1;
          if (pend_start_r)
          begin
            take_start = 1'b1;
            fd_nxt = new_area_r;
            sq_nxt = lanrx_pkg::SQ_FD_CMD;
            rnr_nxt = 1'b0;
          end
          else if (fd_el_r && fd_s_r)
            ru_nxt = lanrx_pkg::RU_IDLE;
          else if (fd_s_r)
            ru_nxt = lanrx_pkg::RU_SUSP;
          else if (fd_el_r || out_r || nospace_r)
            ru_nxt = lanrx_pkg::RU_NORES;
          else if (pend_susp_r)
          begin
            take_susp = 1'b1;
            ru_nxt = lanrx_pkg::RU_SUSP;
          end
          else
          begin
            sq_nxt = lanrx_pkg::SQ_FD_CMD;
            rnr_nxt = 1'b0;
          end
        end
      lanrx_pkg::SQ_DISCARD:
        if (pend_start_r)
        begin
          take_start = 1'b1;
          fd_nxt = new_area_r;
          sq_nxt = lanrx_pkg::SQ_FD_CMD;
        end
        else if (pend_susp_r)
        begin
          take_susp = 1'b1;
          ru_nxt = lanrx_pkg::RU_SUSP;
          rnr_nxt = 1'b1;
          sq_nxt = lanrx_pkg::SQ_OFF;
        end
        else
          sq_nxt = lanrx_pkg::SQ_FD_CMD;
    endcase
    // Host commands: start and suspend applied only at a frame boundary, resume and abort at once
    if ((cmd_code == lanrx_pkg::CMD_START || pend_start_r) && quiet)
    begin
      take_start = 1'b1;
      fd_nxt = pend_start_r ? new_area_r : cmd_area;
      ru_nxt = lanrx_pkg::RU_READY;
      sq_nxt = lanrx_pkg::SQ_FD_CMD;
    end
    else if ((cmd_code == lanrx_pkg::CMD_SUSPEND || pend_susp_r) && quiet && ru_r == lanrx_pkg::RU_READY)
    begin
      take_susp = 1'b1;
      ru_nxt = lanrx_pkg::RU_SUSP;
      rnr_nxt = 1'b1;
    end
    else if (cmd_code == lanrx_pkg::CMD_RESUME && ru_r == lanrx_pkg::RU_SUSP)
    begin
      ru_nxt = lanrx_pkg::RU_READY;
      if (sq_r == lanrx_pkg::SQ_OFF) sq_nxt = lanrx_pkg::SQ_FD_CMD;
    end
    else if (cmd_code == lanrx_pkg::CMD_ABORT)
    begin
      ru_nxt = lanrx_pkg::RU_IDLE;
      rnr_nxt = (ru_r == lanrx_pkg::RU_READY);
    end
    // An aborted access still waits for its answer so the memory port never sees a dropped request
    if (ru_r == lanrx_pkg::RU_IDLE && sq_r != lanrx_pkg::SQ_OFF && (!mem.req || mem_ack))
      sq_nxt = lanrx_pkg::SQ_OFF;
  end

  // ----------------------------------------
  // Memory request selection
  // ----------------------------------------
  always_comb
  begin
    m_acc = 1'b1;
    m_we = 1'b0;
    m_addr = 24'h000000;
    m_wd = 16'h0000;
    unique case (sq_r)
      lanrx_pkg::SQ_FD_CMD: m_addr = daddr(base_r, fd_r + lanrx_pkg::FD_CMD);
      lanrx_pkg::SQ_FD_LINK: m_addr = daddr(base_r, fd_r + lanrx_pkg::FD_LINK);
      lanrx_pkg::SQ_FD_BDP: m_addr = daddr(base_r, fd_r + lanrx_pkg::FD_BDP);
      lanrx_pkg::SQ_FD_BUSY:
      begin
        m_we = 1'b1;
        m_addr = daddr(base_r, fd_r + lanrx_pkg::FD_STAT);
        m_wd = lanrx_pkg::FD_BUSY_WORD;
      end
      lanrx_pkg::SQ_BD_SIZE: m_addr = daddr(base_r, bd_r + lanrx_pkg::BD_SIZE);
      lanrx_pkg::SQ_BD_ALO: m_addr = daddr(base_r, bd_r + lanrx_pkg::BD_ALO);
      lanrx_pkg::SQ_BD_AHI: m_addr = daddr(base_r, bd_r + lanrx_pkg::BD_AHI);
      lanrx_pkg::SQ_BD_NEXT: m_addr = daddr(base_r, bd_r + lanrx_pkg::BD_NEXT);
      lanrx_pkg::SQ_WORD:
      begin
        m_we = 1'b1;
        m_addr = word_addr_r;
        m_wd = word_r;
      end
      lanrx_pkg::SQ_BD_CLOSE:
      begin
        m_we = 1'b1;
        m_addr = daddr(base_r, close_bd + lanrx_pkg::BD_CNT);
        m_wd = {end_r, 1'b1, close_cnt};
      end
      lanrx_pkg::SQ_NEXT_BDP:
      begin
        m_we = 1'b1;
        m_addr = daddr(base_r, link_r + lanrx_pkg::FD_BDP);
        m_wd = next_free;
      end
      lanrx_pkg::SQ_FD_DONE:
      begin
        m_we = 1'b1;
        m_addr = daddr(base_r, fd_r + lanrx_pkg::FD_STAT);
        m_wd = fd_status;
      end
      default: m_acc = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Bus slave and outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      cfg_keep_r <= 1'b0;
      cfg_aib_r <= 1'b0;
      base_r <= 24'h000000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= ahb_go && hwrite;
      wr_addr_r <= ra;
      if (ahb_go && !hwrite) hrdata <= rd_mux;
      if (wr_pend_r && wr_addr_r == lanrx_pkg::REG_CFG)
      begin
        cfg_keep_r <= hwdata[lanrx_pkg::CFG_KEEP_BIT];
        cfg_aib_r <= hwdata[lanrx_pkg::CFG_AIB_BIT];
      end
      if (wr_pend_r && wr_addr_r == lanrx_pkg::REG_BASE) base_r <= hwdata[23:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ru_r <= lanrx_pkg::RU_IDLE;
      sq_r <= lanrx_pkg::SQ_OFF;
      fd_r <= 16'h0000;
      rnr_irq <= 1'b0;
      fr_irq <= 1'b0;
      mem <= '0;
      pend_start_r <= 1'b0;
      pend_susp_r <= 1'b0;
      new_area_r <= 16'h0000;
    end
    else
    begin
      ru_r <= ru_nxt;
      sq_r <= sq_nxt;
      fd_r <= fd_nxt;
      rnr_irq <= rnr_nxt;
      fr_irq <= fr_nxt;
      // Request fields are frozen while a request is outstanding
      if (mem.req)
        mem.req <= !mem_ack;
      else
        mem <= '{req: m_acc && ru_r != lanrx_pkg::RU_IDLE, we: m_we, addr: m_addr, wdata: m_wd};
      if (cmd_code == lanrx_pkg::CMD_START && !quiet)
      begin
        pend_start_r <= 1'b1;
        new_area_r <= cmd_area;
      end
      else if (take_start || cmd_code == lanrx_pkg::CMD_ABORT)
        pend_start_r <= 1'b0;
      if (cmd_code == lanrx_pkg::CMD_SUSPEND && !quiet && ru_r == lanrx_pkg::RU_READY)
        pend_susp_r <= 1'b1;
      else if (take_susp || take_start || cmd_code == lanrx_pkg::CMD_ABORT || cmd_code == lanrx_pkg::CMD_RESUME)
        pend_susp_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Descriptor fields and frame data path
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {link_r, bd_r, bd_next_r, prev_bd_r, word_r} <= '0;
      {size_r, cnt_r, prev_size_r, baddr_r, word_addr_r, hdr_cnt_r} <= '0;
      {fd_el_r, fd_s_r, bd_el_r, prev_valid_r, out_r, end_r, nospace_r, ovr_r, in_buf_r} <= '0;
      {crc_r, aln_r, short_r, noeof_r, in_frame_r, storing_r} <= '0;
    end
    else
    begin
      if (sq_nxt == lanrx_pkg::SQ_FD_CMD && sq_r != lanrx_pkg::SQ_FD_CMD)
        {cnt_r, hdr_cnt_r, prev_valid_r, out_r, end_r, nospace_r, ovr_r, crc_r, aln_r, short_r, noeof_r} <= '0;
      if (acked && sq_r == lanrx_pkg::SQ_FD_CMD) {fd_el_r, fd_s_r} <= mem_rdata[lanrx_pkg::FLAG_HI:lanrx_pkg::FLAG_LO];
      if (acked && sq_r == lanrx_pkg::SQ_FD_LINK) link_r <= mem_rdata;
      if (acked && sq_r == lanrx_pkg::SQ_FD_BDP) bd_r <= mem_rdata;
      if (acked && sq_r == lanrx_pkg::SQ_BD_SIZE)
      begin
        bd_el_r <= mem_rdata[lanrx_pkg::FLAG_HI];
        size_r <= mem_rdata[lanrx_pkg::BCNT_W-1:0];
      end
      if (acked && sq_r == lanrx_pkg::SQ_BD_ALO) baddr_r[15:0] <= mem_rdata;
      if (acked && sq_r == lanrx_pkg::SQ_BD_AHI) baddr_r[23:16] <= mem_rdata[7:0];
      if (acked && sq_r == lanrx_pkg::SQ_BD_NEXT) bd_next_r <= mem_rdata;
      if (acked && sq_r == lanrx_pkg::SQ_BD_CLOSE && !end_r)
      begin
        if (bd_el_r)
          out_r <= 1'b1;
        else
        begin
          prev_bd_r <= bd_r;
          prev_size_r <= cnt_r;
          prev_valid_r <= 1'b1;
          cnt_r <= 14'h0000;
          bd_r <= bd_next_r;
        end
      end
      if (byte_ok && hdr_phase)
      begin
        word_addr_r <= daddr(base_r, fd_r + lanrx_pkg::FD_ADDR + {12'h000, hdr_cnt_r[3:1], 1'b0});
        hdr_cnt_r <= hdr_cnt_r + 4'h1;
        in_buf_r <= 1'b0;
      end
      else if (byte_ok && byte_drop)
        nospace_r <= 1'b1;
      else if (byte_ok)
      begin
        word_addr_r <= baddr_r + {10'h000, cnt_r[13:1], 1'b0};
        cnt_r <= cnt_r + 14'h0001;
        in_buf_r <= 1'b1;
      end
      // Odd final byte leaves the high byte of its word as zero
      if (byte_ok && !byte_drop && !byte_pos) word_r <= {8'h00, rx.data};
      if (byte_ok && !byte_drop && byte_pos) word_r[15:8] <= rx.data;
      if (ovr_now) ovr_r <= 1'b1;
      if (end_evt && storing_now)
      begin
        end_r <= 1'b1;
        {crc_r, aln_r, short_r, noeof_r} <= {rx.crc_err, rx.align_err, rx.too_short, rx.no_eof};
      end
      if (rx.valid) in_frame_r <= !rx.last;
      if (ru_r == lanrx_pkg::RU_IDLE || end_evt)
        storing_r <= 1'b0;
      else if (start_ok)
        storing_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Statistics counters
  // ----------------------------------------
  // Counters wrap; software reads them as free-running totals
  wire stat_on = ru_r != lanrx_pkg::RU_IDLE && end_evt;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      {crc_cnt_r, aln_cnt_r, ovr_cnt_r, rsc_cnt_r} <= '0;
    else
    begin
      if (stat_on && rx.crc_err) crc_cnt_r <= crc_cnt_r + 1'b1;
      if (stat_on && rx.align_err) aln_cnt_r <= aln_cnt_r + 1'b1;
      if (stat_on && storing_now && (ovr_r || ovr_now)) ovr_cnt_r <= ovr_cnt_r + 1'b1;
      if (stat_on && !storing_now && (ru_r == lanrx_pkg::RU_NORES || ru_r == lanrx_pkg::RU_READY))
        rsc_cnt_r <= rsc_cnt_r + 1'b1;
    end
  end
endmodule

// ### lanrx_pkg.sv
// Constants, types and carriers shared by the LAN receive unit.
// Assumes a 16-bit descriptor memory port and byte-wide frame data from a link receiver on ref_clk.
//
// Functional notes
// - One frame descriptor per frame, buffers as needed
// - Exhausted descriptor or buffer list: notify, no-resources
// - Status word bits 13,11,10,9,8,7,6 flag outcome
// - Errored frames stored only when keep option set
// - Suspend flag on descriptor suspends after frame
// - Busy set at setup; busy/complete written together
// - Buffer pointer 0FFFFH means no buffer attached
// - Address and type fields packed, omitted if in-buffer
// - Respect buffer size; prefetch next buffer descriptor
// - Kept frame: write next free buffer pointer forward
// - Device sets last-buffer flag on frame end buffer
// - Device sets filled flag; count valid only then
// - 14-bit actual count per used buffer
// - 24-bit buffer start address, even in word mode
// - Idle: ignore frames, touch no memory
// - No-resources: detect frames, store none, count losses
// - Store only when ready; otherwise discard, keep stats
// - Commands: no-op, suspend, resume, start, abort
// - Not-ready interrupt on leaving ready
// - Start request acted on only at frame end; code applies it at once when no frame or setup is in progress
// - Frame-received interrupt after each completed frame
// - Frames lost during setup count resource or overrun
package lanrx_pkg;
  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_BASE = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_CRC = 8'h10;
  localparam logic [7:0] REG_ALN = 8'h14;
  localparam logic [7:0] REG_OVR = 8'h18;
  localparam logic [7:0] REG_RSC = 8'h1C;
  localparam int CMD_AREA_LSB = 16;
  localparam int CFG_KEEP_BIT = 0;
  localparam int CFG_AIB_BIT = 1;
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_RESUME = 3'h2;
  localparam logic [2:0] CMD_SUSPEND = 3'h3;
  localparam logic [2:0] CMD_ABORT = 3'h4;
  // ----------------------------------------
  // Descriptor layout (byte offsets, bits)
  // ----------------------------------------
  localparam logic [15:0] FD_STAT = 16'h0000;
  localparam logic [15:0] FD_CMD = 16'h0002;
  localparam logic [15:0] FD_LINK = 16'h0004;
  localparam logic [15:0] FD_BDP = 16'h0006;
  localparam logic [15:0] FD_ADDR = 16'h0008;
  localparam logic [15:0] BD_CNT = 16'h0000;
  localparam logic [15:0] BD_NEXT = 16'h0002;
  localparam logic [15:0] BD_ALO = 16'h0004;
  localparam logic [15:0] BD_AHI = 16'h0006;
  localparam logic [15:0] BD_SIZE = 16'h0008;
  localparam logic [15:0] NO_BD = 16'hFFFF;
  localparam logic [15:0] FD_BUSY_WORD = 16'h4000;
  localparam logic [3:0] HDR_LEN = 4'hE;
  localparam int ST_C = 15;
  localparam int ST_OK = 13;
  localparam int ST_CRC = 11;
  localparam int ST_ALN = 10;
  localparam int ST_NOSP = 9;
  localparam int ST_OVR = 8;
  localparam int ST_SHORT = 7;
  localparam int ST_NOEOF = 6;
  localparam int FLAG_HI = 15;
  localparam int FLAG_LO = 14;
  localparam int BCNT_W = 14;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {RU_IDLE, RU_SUSP, RU_NORES, RU_READY} lanrx_ru_t;
  typedef enum logic [3:0] {SQ_OFF, SQ_FD_CMD, SQ_FD_LINK, SQ_FD_BDP, SQ_FD_BUSY, SQ_BD_SIZE, SQ_BD_ALO,
    SQ_BD_AHI, SQ_BD_NEXT, SQ_ARMED, SQ_WORD, SQ_BD_CLOSE, SQ_NEXT_BDP, SQ_FD_DONE, SQ_DISCARD} lanrx_sq_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic crc_err;
    logic align_err;
    logic too_short;
    logic no_eof;
  } lanrx_link_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } lanrx_mem_t;
endpackage

// ### lanrx_checker.sv
// Port assertions for the LAN receive unit.
// Assumes a bind onto lanrx_receive_unit; one clock, async active-low reset.
`timescale 1ns/1ns
module lanrx_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire lanrx_pkg::lanrx_mem_t mem,
  input wire logic mem_ack,
  input wire logic rnr_irq,
  input wire logic fr_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr_seen_r;
  // Only a register write can wake the unit, so a read leaves it quiet
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      wr_seen_r <= 1'b0;
    else if (hsel && hready && htrans[1] && hwrite)
      wr_seen_r <= 1'b1;
  end
  sequence s_wait;
    mem.req && !mem_ack;
  endsequence
  sequence s_done;
    mem.req && mem_ack;
  endsequence
  logic s_done_w;
  assign s_done_w = mem.req && mem.we && mem_ack && mem.wdata[15] && !mem.wdata[14];
  chk_fr_status: assert property (fr_irq |-> $past(s_done_w))
    else $error("frame event without a completed status write");
  chk_fr_ok_bit: assert property (fr_irq |-> $past(mem.wdata[13]) == !$past(|mem.wdata[11:6]))
    else $error("ok bit disagrees with error bits");
  chk_fr_pulse: assert property (fr_irq |=> !fr_irq)
    else $error("frame event longer than one cycle");
  chk_rnr_pulse: assert property (rnr_irq |=> !rnr_irq)
    else $error("not-ready event longer than one cycle");
  chk_idle_quiet: assert property (!wr_seen_r |-> !mem.req)
    else $error("memory touched while idle");
  chk_idle_no_irq: assert property (!wr_seen_r |-> !fr_irq && !rnr_irq)
    else $error("event raised while idle");
  chk_req_hold: assert property (s_wait |=> mem.req && $stable(mem))
    else $error("memory request changed before ack");
  chk_req_drop: assert property (s_done |=> !mem.req)
    else $error("memory request held after ack");
endmodule

// ### lanrx_host_mem.sv
// Host side model: shared 16-bit descriptor memory answering the unit.
// Assumes the bench seeds descriptor images into m after reset.
`timescale 1ns/1ns
module lanrx_host_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire lanrx_pkg::lanrx_mem_t mem,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] m [0:255];
  logic [1:0] wait_r;
  logic [15:0] last_r;
  initial
  begin
    for (int i = 0; i < 256; i++)
      m[i] = 16'h0000;
  end
  // Off the ack cycle the data lines show the inverse, never a stale match
  assign mem_rdata = mem_ack ? m[mem.addr[8:1]] : ~last_r;
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      last_r <= 16'h0000;
    end
    else
    begin
      mem_ack <= mem.req && !mem_ack && wait_r >= lat;
      wait_r <= (mem.req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      if (mem_ack)
        last_r <= mem_rdata;
      if (mem_ack && mem.we)
        m[mem.addr[8:1]] <= mem.wdata;
    end
  end
endmodule

// ### tb_top.sv
// Bench: AHB-Lite register tasks, byte link driver and host memory model.
// Assumes zero-wait register slave and descriptors in low memory, page base 0.
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, mem_ack, rnr_irq, fr_irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, lat;
  logic [15:0] mem_rdata;
  lanrx_pkg::lanrx_mem_t mem;
  lanrx_pkg::lanrx_link_t rx;
  int failures, n_checks, n_req, n_fr, n_rnr, r0;
  logic [23:0] img [9] = '{24'h128000, 24'h140030, 24'h160040, 24'h36FFFF, 24'h420050, 24'h440080,
    24'h480002, 24'h540090, 24'h588004};
  assign hready = hreadyout;
  lanrx_receive_unit dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx(rx), .rnr_irq(rnr_irq),
    .fr_irq(fr_irq));
  lanrx_host_mem u_host (.ref_clk(ref_clk), .nrst(nrst), .mem(mem), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    n_req += (mem.req === 1'b1 && mem_ack === 1'b1);
    n_fr += (fr_irq === 1'b1);
    n_rnr += (rnr_irq === 1'b1);
  end
  function automatic logic [31:0] mw(input logic [7:0] a);
    return {16'h0000, u_host.m[a[7:1]]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait on hready, or on one of the event counts when sel is 1..3
  task automatic await(input int sel, input int val);
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge ref_clk);
      if ((sel == 0) ? (hready === 1'b1) : ((sel == 1 ? n_req : sel == 2 ? n_fr : n_rnr) >= val))
        return;
    end
    failures++;
    close_out();
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    await(0, 0);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    await(0, 0);
    q = hrdata;
  endtask
  // Bytes are spaced widely: the link has no back-pressure
  task automatic send(input int n, input logic err);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      rx <= {1'b1, 8'hA0 + 8'(i), i == n - 1, err && i == n - 1, 3'h0};
      @(posedge ref_clk);
      rx <= '0;
      repeat (30) @(posedge ref_clk);
    end
  endtask
  initial
  begin
    {nrst, hsel, hwrite, haddr, hwdata, htrans, rx, lat} = '0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    foreach (img[k]) u_host.m[img[k][23:17]] = img[k][15:0];
    send(1, 1'b0);
    chk(n_req, 0);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    $display("test 1 done");
    lat <= 2'h2;
    ahb(1'b1, 8'h04, 32'h2);
    ahb(1'b1, 8'h00, 32'h00100001);
    await(1, 8);
    chk(mw(8'h10), 32'h4000);
    send(3, 1'b0);
    await(2, 1);
    chk(mw(8'h80), 32'hA1A0);
    chk(mw(8'h40), 32'h4002);
    chk(mw(8'h90) & 32'hFF, 32'hA2);
    chk(mw(8'h50), 32'hC001);
    chk(mw(8'h10), 32'hA000);
    await(3, 1);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'h3, 32'h2);
    $display("test 2 done");
    lat <= 2'h0;
    r0 = n_req;
    send(1, 1'b1);
    chk(n_req, r0);
    ahb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h1);
    ahb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h1);
    $display("test 3 done");
    ahb(1'b1, 8'h00, 32'h00300001);
    await(3, 2);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'h3, 32'h2);
    chk(mw(8'h30), 32'h0);
    $display("test 4 done");
    r0 = n_req;
    ahb(1'b1, 8'h00, 32'h00100001);
    await(1, r0 + 8);
    ahb(1'b1, 8'h00, 32'h3);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'h3, 32'h1);
    ahb(1'b1, 8'h00, 32'h2);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'h3, 32'h3);
    ahb(1'b1, 8'h00, 32'h4);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(q & 32'h3, 32'h0);
    chk(n_rnr, 4);
    chk(n_fr, 1);
    chk(32'(hresp), 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    $display("test 5 done");
    close_out();
  end
endmodule
bind lanrx_receive_unit lanrx_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .mem(mem), .mem_ack(mem_ack), .rnr_irq(rnr_irq), .fr_irq(fr_irq));
